// ==== acd_defines.svh ====
`ifndef ACD_DEFINES_SVH
`define ACD_DEFINES_SVH
// power-up values
`define ACD_ZERO8 8'h00
`define ACD_SETUP_RST 8'h28
`define ACD_DAC_ONES 12'hfff
`define ACD_DAC_ZEROS 12'h000
// ADC clock modes
`define ACD_CK_TRIG 2'b00
`define ACD_CK_EXTREQ 2'b01
`define ACD_CK_SERIAL 2'b10
`define ACD_CK_SCLK 2'b11
// input-mode register select codes
`define ACD_IMODE_UNI 2'b10
`define ACD_IMODE_BIP 2'b11
// full-byte commands
`define ACD_GPIO_CFG 8'h03
`define ACD_GPIO_WR 8'h02
`define ACD_GPIO_RD 8'h01
`define ACD_NOP 8'h00
// additional byte counts
`define ACD_EXTRA_ONE 2'd1
`define ACD_EXTRA_TWO 2'd2
// serial framing
`define ACD_BIT_LAST 3'd7
`define ACD_BIT_FIRST 3'd0
// reset register bit positions
`define ACD_RST_REQ 2
`define ACD_RST_FBG 0
`endif

// ==== acd_pkg.sv ====
package acd_pkg;
    // serial decoder states, one-hot
    typedef enum logic [1:0] {
        ACD_ST_CMD = 2'b01,
        ACD_ST_DATA = 2'b10
    } acd_state_t;
    // kind of command awaiting data bytes, one-hot
    typedef enum logic [2:0] {
        ACD_K_SETUP = 3'b001,
        ACD_K_DAC = 3'b010,
        ACD_K_GPIO = 3'b100
    } acd_kind_t;
endpackage

// ==== acd_command_decoder.sv ====
`include "acd_defines.svh"
module acd_command_decoder
    import acd_pkg::*;
#(
    parameter int GPIO_COUNT = 12
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic csN,
    input wire logic sclk,
    input wire logic din,
    input wire logic conversion_start_n,
    input wire logic dac_wakeup_level_select,
    input wire logic conversionDone,
    output logic eocN,
    output logic startConversion,
    output logic blocksShutdown,
    output logic [7:0] conversion_control,
    output logic [7:0] setup_control,
    output logic [7:0] averaging_control,
    output logic [7:0] reset_control,
    output logic averagingActive,
    output logic [7:0] pairDifferential,
    output logic [7:0] pairBipolar,
    output logic [11:0] dacInput,
    output logic [3:0] dacSelect,
    output logic dacStrobe,
    output logic [7:0] gpioCommand,
    output logic [15:0] gpioData,
    output logic gpioStrobe
);
    ////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [2:0] sclkS, csS, cnvS;
    logic [1:0] dinS, wakeS;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sclkS <= 3'h0;
            csS <= 3'h7;
            cnvS <= 3'h7;
            dinS <= 2'h0;
        end else begin
            sclkS <= {sclkS[1:0], sclk};
            csS <= {csS[1:0], csN};
            cnvS <= {cnvS[1:0], conversion_start_n};
            dinS <= {dinS[0], din};
        end
    end
    // strap sync runs through reset so its level is valid at the first edge after release
    always_ff @(posedge mclk) begin
        wakeS <= {wakeS[0], dac_wakeup_level_select};
    end
    logic sclkFall, csFall, cnvFall, csLow;
    assign sclkFall = sclkS[2] & ~sclkS[1];
    assign csFall = csS[2] & ~csS[1];
    assign cnvFall = cnvS[2] & ~cnvS[1];
    assign csLow = ~csS[1];
    ////////////////////////////////////////////////////////////////
    // state
    acd_state_t state, next_state;
    acd_kind_t kind, next_kind;
    logic [2:0] bitCount, next_bitCount;
    logic [6:0] shiftReg, next_shiftReg;
    logic [1:0] bytesLeft, next_bytesLeft;
    logic [7:0] dataWord, next_dataWord;
    logic dacInitPending, next_dacInitPending;
    logic [7:0] next_conversion, next_setup, next_averaging, next_reset;
    logic [7:0] uniMode, next_uniMode, bipMode, next_bipMode;
    logic [11:0] next_dacInput;
    logic [3:0] next_dacSelect;
    logic [7:0] next_gpioCommand;
    logic [15:0] next_gpioData;
    logic next_dacStrobe, next_gpioStrobe, next_start, next_eocN, next_shutdown;
    logic [7:0] rxByte;
    logic byteDone;
    logic [1:0] clockMode;
    assign rxByte = {shiftReg, dinS[1]};
    assign byteDone = sclkFall & csLow & (bitCount == `ACD_BIT_LAST);
    assign clockMode = setup_control[5:4];
    ////////////////////////////////////////////////////////////////
    // serial shifter, command decode and register writes
    always_comb begin
        next_state = state;
        next_kind = kind;
        next_bitCount = bitCount;
        next_shiftReg = shiftReg;
        next_bytesLeft = bytesLeft;
        next_dataWord = dataWord;
        next_dacInitPending = 1'b0;
        next_conversion = conversion_control;
        next_setup = setup_control;
        next_averaging = averaging_control;
        next_reset = reset_control;
        next_uniMode = uniMode;
        next_bipMode = bipMode;
        next_dacInput = dacInput;
        next_dacSelect = dacSelect;
        next_gpioCommand = gpioCommand;
        next_gpioData = gpioData;
        next_dacStrobe = 1'b0;
        next_gpioStrobe = 1'b0;
        next_start = 1'b0;
        next_shutdown = blocksShutdown;
        // wake-up level caught after reset release
        if (dacInitPending) begin
            next_dacInput = wakeS[1] ? `ACD_DAC_ONES : `ACD_DAC_ZEROS;
        end
        if (!csLow) begin
            // chip select high clears the serial side
            next_state = ACD_ST_CMD;
            next_bitCount = `ACD_BIT_FIRST;
            next_bytesLeft = 2'd0;
        end else if (sclkFall) begin
            next_shiftReg = rxByte[6:0];
            next_bitCount = bitCount + 3'd1;
        end
        if (byteDone && state == ACD_ST_CMD) begin
            if (rxByte[7]) begin
                next_conversion = rxByte;
                // serial write starts conversions outside pin-trigger modes
                next_start = (clockMode == `ACD_CK_SERIAL) || (clockMode == `ACD_CK_SCLK);
            end else if (rxByte[6]) begin
                next_setup = {2'b00, rxByte[5:0]};
                next_kind = ACD_K_SETUP;
                next_bytesLeft = `ACD_EXTRA_ONE;
                next_state = ACD_ST_DATA;
            end else if (rxByte[5]) begin
                next_averaging = {3'b000, rxByte[4:0]};
            end else if (rxByte[4]) begin
                next_kind = ACD_K_DAC;
                next_bytesLeft = `ACD_EXTRA_TWO;
                next_state = ACD_ST_DATA;
            end else if (rxByte[3]) begin
                next_reset = {5'b00000, rxByte[2:0]};
                if (rxByte[`ACD_RST_REQ]) begin
                    // reset request restores defaults and shuts down
                    next_conversion = `ACD_ZERO8;
                    next_setup = `ACD_SETUP_RST;
                    next_averaging = `ACD_ZERO8;
                    next_uniMode = `ACD_ZERO8;
                    next_bipMode = `ACD_ZERO8;
                    next_shutdown = 1'b1;
                end
                if (rxByte[`ACD_RST_FBG]) begin
                    next_shutdown = 1'b0;
                end
            end else if (GPIO_COUNT != 0 && (rxByte == `ACD_GPIO_CFG || rxByte == `ACD_GPIO_WR
                         || rxByte == `ACD_GPIO_RD)) begin
                next_gpioCommand = rxByte;
                next_kind = ACD_K_GPIO;
                next_bytesLeft = (GPIO_COUNT > 4) ? `ACD_EXTRA_TWO : `ACD_EXTRA_ONE;
                next_state = ACD_ST_DATA;
            end
            // no-op and GPIO bytes without GPIO pins change nothing
        end else if (byteDone && state == ACD_ST_DATA) begin
            next_dataWord = rxByte; // previous data byte kept
            next_bytesLeft = bytesLeft - 2'd1;
            if (bytesLeft == 2'd1) begin
                next_state = ACD_ST_CMD;
                if (kind == ACD_K_SETUP) begin
                    // input-mode select chooses unipolar or bipolar map
                    if (setup_control[1:0] == `ACD_IMODE_UNI) begin
                        next_uniMode = rxByte;
                    end else if (setup_control[1:0] == `ACD_IMODE_BIP) begin
                        next_bipMode = rxByte;
                    end
                end else if (kind == ACD_K_DAC) begin
                    next_dacSelect = dataWord[7:4];
                    next_dacInput = {dataWord[3:0], rxByte};
                    next_dacStrobe = 1'b1;
                end else begin
                    next_gpioData = {dataWord[7:0], rxByte};
                    next_gpioStrobe = 1'b1;
                end
            end
        end
        // pin triggers in modes 00 and 01
        if (cnvFall && (clockMode == `ACD_CK_TRIG || clockMode == `ACD_CK_EXTREQ)) begin
            next_start = 1'b1;
        end
        if (next_start) begin
            next_shutdown = 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////
    // end-of-conversion flag, falls win over completion
    always_comb begin
        next_eocN = eocN;
        if (conversionDone) begin
            next_eocN = 1'b0;
        end
        if (csFall || cnvFall || clockMode == `ACD_CK_SCLK) begin
            next_eocN = 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ACD_ST_CMD;
            kind <= ACD_K_SETUP;
            bitCount <= `ACD_BIT_FIRST;
            shiftReg <= 7'h00;
            bytesLeft <= 2'd0;
            dataWord <= `ACD_ZERO8;
            dacInitPending <= 1'b1;
            conversion_control <= `ACD_ZERO8;
            setup_control <= `ACD_SETUP_RST;
            averaging_control <= `ACD_ZERO8;
            reset_control <= `ACD_ZERO8;
            uniMode <= `ACD_ZERO8;
            bipMode <= `ACD_ZERO8;
            dacInput <= `ACD_DAC_ZEROS;
            dacSelect <= 4'h0;
            gpioCommand <= `ACD_ZERO8;
            gpioData <= 16'h0000;
            dacStrobe <= 1'b0;
            gpioStrobe <= 1'b0;
            startConversion <= 1'b0;
            blocksShutdown <= 1'b1;
            eocN <= 1'b1;
            averagingActive <= 1'b0;
            pairDifferential <= `ACD_ZERO8;
            pairBipolar <= `ACD_ZERO8;
        end else begin
            state <= next_state;
            kind <= next_kind;
            bitCount <= next_bitCount;
            shiftReg <= next_shiftReg;
            bytesLeft <= next_bytesLeft;
            dataWord <= next_dataWord;
            dacInitPending <= next_dacInitPending;
            conversion_control <= next_conversion;
            setup_control <= next_setup;
            averaging_control <= next_averaging;
            reset_control <= next_reset;
            uniMode <= next_uniMode;
            bipMode <= next_bipMode;
            dacInput <= next_dacInput;
            dacSelect <= next_dacSelect;
            gpioCommand <= next_gpioCommand;
            gpioData <= next_gpioData;
            dacStrobe <= next_dacStrobe;
            gpioStrobe <= next_gpioStrobe;
            startConversion <= next_start;
            blocksShutdown <= next_shutdown;
            eocN <= next_eocN;
            // averaging suppressed in serial-clocked mode
            averagingActive <= next_averaging[4] & (next_setup[5:4] != `ACD_CK_SCLK);
            // bit n covers pair 2n positive, 2n+1 negative; clear bits are single-ended unipolar
            pairDifferential <= next_uniMode | next_bipMode;
            // bipolar pairs code two's complement, the rest straight binary
            pairBipolar <= next_bipMode;
        end
    end
    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    property p_conv_write;
        byteDone && state == ACD_ST_CMD && rxByte[7] |=> conversion_control == $past(rxByte) && state == ACD_ST_CMD;
    endproperty
    a_conv_write: assert property (p_conv_write) else $error("conversion write lost");
    property p_setup_extra;
        byteDone && state == ACD_ST_CMD && rxByte[7:6] == 2'b01 |=> state == ACD_ST_DATA && bytesLeft == 2'd1;
    endproperty
    a_setup_extra: assert property (p_setup_extra) else $error("setup byte count wrong");
    property p_dac_extra;
        byteDone && state == ACD_ST_CMD && rxByte[7:4] == 4'b0001 |=> bytesLeft == 2'd2;
    endproperty
    a_dac_extra: assert property (p_dac_extra) else $error("DAC byte count wrong");
    property p_nop;
        byteDone && state == ACD_ST_CMD && rxByte == `ACD_NOP |=> state == ACD_ST_CMD && $stable(setup_control);
    endproperty
    a_nop: assert property (p_nop) else $error("no-op changed state");
    property p_eoc_mode11;
        clockMode == `ACD_CK_SCLK |=> eocN;
    endproperty
    a_eoc_mode11: assert property (p_eoc_mode11) else $error("eoc low in mode 11");
    property p_eoc_cs;
        csFall |=> eocN;
    endproperty
    a_eoc_cs: assert property (p_eoc_cs) else $error("eoc not raised by chip select");
    property p_eoc_done;
        conversionDone && !csFall && !cnvFall && clockMode != `ACD_CK_SCLK |=> !eocN;
    endproperty
    a_eoc_done: assert property (p_eoc_done) else $error("eoc not lowered");
    property p_mode10_start;
        byteDone && state == ACD_ST_CMD && rxByte[7] && clockMode == `ACD_CK_SERIAL |=> startConversion;
    endproperty
    a_mode10_start: assert property (p_mode10_start) else $error("serial start missed");
    property p_pin_start;
        cnvFall && clockMode == `ACD_CK_EXTREQ |=> startConversion ##1 !startConversion || cnvFall;
    endproperty
    a_pin_start: assert property (p_pin_start) else $error("pin start missed");
    property p_cs_reset;
        !csLow |=> bitCount == `ACD_BIT_FIRST && state == ACD_ST_CMD;
    endproperty
    a_cs_reset: assert property (p_cs_reset) else $error("serial not reset");
    c_setup: cover property (byteDone && state == ACD_ST_DATA && kind == ACD_K_SETUP && bytesLeft == 2'd1);
    c_dac: cover property (dacStrobe);
    c_gpio: cover property (gpioStrobe);
    c_eoc: cover property (!eocN ##1 eocN);
endmodule

// ==== acd_spi_master.sv ====
module acd_spi_master (
    output logic csN,
    output logic sclk,
    output logic din
);
    timeunit 1ns;
    timeprecision 1ps;
    int halfNs = 24;
    ////////////////////////////////////////
    // idle: clock parked low, device deselected
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        din = 1'b1;
    end
    // select device, slow clock for serial-timed mode
    task automatic frameStart(input bit slow);
        halfNs = slow ? 140 : 24;
        csN = 1'b0;
        #(halfNs);
    endtask
    // msb first, data set on rise, held past the sampling fall
    task automatic sendBits(input logic [7:0] b, input int nBits);
        for (int i = 7; i > 7 - nBits; i--) begin
            sclk = 1'b1;
            din = b[i];
            #(halfNs);
            sclk = 1'b0;
            #(halfNs);
        end
    endtask
    // deselect; released data line shows inverse of last bit
    task automatic frameEnd();
        din = ~din;
        csN = 1'b1;
        #(halfNs);
    endtask
endmodule

// ==== tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, csN, sclk, din, eocN, startConversion, blocksShutdown, averagingActive;
    logic dacStrobe, gpioStrobe, gpioStrobeNg;
    logic rst_b = 1'b0;
    logic conversion_start_n = 1'b1;
    logic wakeLevel = 1'b1;
    logic conversionDone = 1'b0;
    logic [7:0] convCtl, setupCtl, avgCtl, rstCtl, pairDiff, pairBip, gpioCommand, gpioCommandNg;
    logic [11:0] dacInput;
    logic [3:0] dacSelect;
    logic [15:0] gpioData;
    int numErrors = 0;
    int numChecks = 0;
    int nStart = 0, nDac = 0, nGpio = 0, nGpioNg = 0;
    ////////////////////////////////////////
    acd_spi_master i_acd_spi_master (.csN(csN), .sclk(sclk), .din(din));
    acd_command_decoder #(.GPIO_COUNT(12)) i_acd_command_decoder (
        .mclk(mclk), .rst_b(rst_b), .csN(csN), .sclk(sclk), .din(din),
        .conversion_start_n(conversion_start_n), .dac_wakeup_level_select(wakeLevel),
        .conversionDone(conversionDone), .eocN(eocN), .startConversion(startConversion),
        .blocksShutdown(blocksShutdown), .conversion_control(convCtl), .setup_control(setupCtl),
        .averaging_control(avgCtl), .reset_control(rstCtl), .averagingActive(averagingActive),
        .pairDifferential(pairDiff), .pairBipolar(pairBip), .dacInput(dacInput),
        .dacSelect(dacSelect), .dacStrobe(dacStrobe), .gpioCommand(gpioCommand),
        .gpioData(gpioData), .gpioStrobe(gpioStrobe));
    // variant without gpio pins on the same serial lines
    acd_command_decoder #(.GPIO_COUNT(0)) i_acd_command_decoder_nogpio (
        .mclk(mclk), .rst_b(rst_b), .csN(csN), .sclk(sclk), .din(din),
        .conversion_start_n(conversion_start_n), .dac_wakeup_level_select(wakeLevel),
        .conversionDone(conversionDone), .eocN(), .startConversion(), .blocksShutdown(),
        .conversion_control(), .setup_control(), .averaging_control(), .reset_control(),
        .averagingActive(), .pairDifferential(), .pairBipolar(), .dacInput(), .dacSelect(),
        .dacStrobe(), .gpioCommand(gpioCommandNg), .gpioData(), .gpioStrobe(gpioStrobeNg));
    ////////////////////////////////////////
    // system clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // count one-cycle strobes
    always @(posedge mclk) begin
        if (startConversion === 1'b1) nStart <= nStart + 1;
        if (dacStrobe === 1'b1) nDac <= nDac + 1;
        if (gpioStrobe === 1'b1) nGpio <= nGpio + 1;
        if (gpioStrobeNg === 1'b1) nGpioNg <= nGpioNg + 1;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        numChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one chip-select frame of whole bytes, then let syncs settle
    task automatic frame(input logic [7:0] bytes[$], input bit slow = 1'b0);
        i_acd_spi_master.frameStart(slow);
        foreach (bytes[k]) i_acd_spi_master.sendBits(bytes[k], 8);
        i_acd_spi_master.frameEnd();
        repeat (8) @(negedge mclk);
    endtask
    // pulse conversion pin low or conversion-done high
    task automatic pulseIn(input bit pin);
        @(negedge mclk);
        if (pin) conversion_start_n = 1'b0;
        else conversionDone = 1'b1;
        repeat (pin ? 4 : 1) @(negedge mclk);
        conversion_start_n = 1'b1;
        conversionDone = 1'b0;
        repeat (8) @(negedge mclk);
    endtask
    task automatic completeRun();
        $display("checks %0d errors %0d", numChecks, numErrors);
        if (numErrors == 0 && numChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    // watchdog
    initial begin
        #100us;
        numErrors++;
        completeRun();
    end
    // main sequence
    initial begin
        repeat (16) @(negedge mclk);
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        chk(blocksShutdown, 1'b1);
        chk(setupCtl, 8'h28);
        chk({convCtl, avgCtl}, 16'h0000);
        chk({rstCtl, pairDiff}, 16'h0000);
        chk({pairBip, gpioCommand}, 16'h0000);
        chk(dacInput, 12'hfff);
        chk(eocN, 1'b1);
        frame({8'h9b});
        chk(convCtl, 8'h9b);
        chk(nStart, 16'd1);
        frame({8'h3d, 8'h09, 8'h62, 8'ha5});
        chk(avgCtl, 8'h1d);
        chk(averagingActive, 1'b1);
        chk({rstCtl, 7'h00, blocksShutdown}, 16'h0100);
        chk(setupCtl, 8'h22);
        chk({pairDiff, pairBip}, 16'ha500);
        frame({8'h63, 8'h0f, 8'h1f, 8'h5a, 8'hbc});
        chk({pairDiff, pairBip}, 16'haf0f);
        chk({dacSelect, dacInput}, 16'h5abc);
        chk(nDac, 16'd1);
        // each gpio command, its two bytes, a no-op, then a conversion command
        for (int k = 0; k < 3; k++) begin
            frame({8'h03 - 8'(k), 8'h12 + 8'(k), 8'h34, 8'h00, 8'h81});
            chk(gpioCommand, 8'h03 - 8'(k));
            chk(gpioData, {8'h12 + 8'(k), 8'h34});
            chk(convCtl, 8'h81);
            chk(nGpio, 16'(k + 1));
        end
        chk({nGpioNg[7:0], gpioCommandNg}, 16'h0000);
        chk(nStart, 16'd4);
        // partial byte dropped when chip select rises
        i_acd_spi_master.frameStart(1'b0);
        i_acd_spi_master.sendBits(8'hff, 5);
        i_acd_spi_master.frameEnd();
        frame({8'h88});
        chk(convCtl, 8'h88);
        pulseIn(1'b0);
        chk(eocN, 1'b0);
        frame({8'h00});
        chk(eocN, 1'b1);
        frame({8'h40});
        chk(setupCtl, 8'h00);
        pulseIn(1'b0);
        pulseIn(1'b1);
        chk(nStart, 16'd6);
        chk(eocN, 1'b1);
        frame({8'h50, 8'h80});
        pulseIn(1'b1);
        chk(nStart, 16'd7);
        frame({8'h70});
        chk(averagingActive, 1'b0);
        pulseIn(1'b0);
        chk(eocN, 1'b1);
        frame({8'h0c}, 1'b1);
        chk({setupCtl, 7'h00, blocksShutdown}, 16'h2801);
        // second reset with wake-up strap low
        wakeLevel = 1'b0;
        repeat (4) @(negedge mclk);
        rst_b = 1'b0;
        repeat (4) @(negedge mclk);
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        chk(dacInput, 12'h000);
        chk({convCtl, setupCtl}, 16'h0028);
        completeRun();
    end
endmodule
